// >>> verilog/dpc_top.sv
// Purpose: protection and filter settings of a servo drive, on APB
// Assumes: one 125 MHz clock, synchronous active-high reset
// Notes: probe, zero-mark and torque-off pins pass a two-stage synchroniser before use
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "dpc_defines.svh"
module dpc_top #(
   parameter int MS_CYCLES = `DPC_MS_NS / `DPC_CLK_NS
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [9:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [15:0] module_temp_i,
   input wire logic [15:0] motor_speed_i,
   input wire logic probe_one_i,
   input wire logic probe_two_i,
   input wire logic zero_mark_signal_i,
   input wire logic torque_off_trip_i,
   input wire logic standstill_i,
   input wire logic warm_restart_i,
   input wire logic overload_warn_i,
   input wire logic overload_trip_i,
   input wire logic stall_overheat_i,
   input wire logic turn_overflow_i,
   input wire logic runaway_detect_i,
   output logic overtemp_o,
   output logic probe_one_o,
   output logic probe_two_o,
   output logic zero_mark_o,
   output logic torque_off_status_o,
   output logic torque_off_fault_o,
   output logic motor_overload_warning_o,
   output logic motor_overload_fault_o,
   output logic locked_rotor_fault_o,
   output logic turn_overflow_fault_o,
   output logic runaway_fault_o,
   output logic fault_o,
   output logic [15:0] rotation_speed_o,
   output logic irq_o
);
   localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);

   dpc_pkg::dpc_state_t r;
   dpc_pkg::dpc_state_t n;
   dpc_pkg::dpc_slot_t slot;
   logic [7:0] idx;
   logic cfg_hit;
   logic in_range;
   logic acc_ok;
   logic [31:0] rdval;
   logic [2:0][9:0] thr;
   logic tick;
   logic setup;
   logic done;

   // round up: a filter never passes a pulse shorter than its setting
   for (genvar c = 0; c < 3; c++) begin : g_thr
      localparam int UNIT = (c == 2) ? `DPC_ZM_UNIT_NS : `DPC_PROBE_UNIT_NS;
      logic [15:0] tv;
      assign tv = (c == 2) ? 16'(r.zm_act) :
                  r.cfg[int'(dpc_pkg::SL_PR1) + c];
      assign thr[c] = 10'((32'(tv) * UNIT + `DPC_CLK_NS - 1) /
                          `DPC_CLK_NS);
   end

   // time constant rounded up to a power of two: a shift, no divider
   function automatic logic [3:0] tc_shift(input logic [15:0] tau);
      logic [3:0] k;
      k = 4'h0;
      for (int i = 0; i < 14; i++) begin
         if ((16'h0001 << i) < tau) begin
            k = 4'(i + 1);
         end
      end
      return k;
   endfunction

   assign idx = paddr_i[9:2];
   assign setup = psel_i && !penable_i;
   assign done = psel_i && penable_i && r.pready;
   assign tick = (r.ms_cnt == MS_LAST);

   always_comb begin
      cfg_hit = 1'b1;
      slot = dpc_pkg::SL_RWY;
      case (idx)
         `DPC_IDX_RWY: slot = dpc_pkg::SL_RWY;
         `DPC_IDX_OTL: slot = dpc_pkg::SL_OTL;
         `DPC_IDX_PR1: slot = dpc_pkg::SL_PR1;
         `DPC_IDX_PR2: slot = dpc_pkg::SL_PR2;
         `DPC_IDX_TOR: slot = dpc_pkg::SL_TOR;
         `DPC_IDX_MOD: slot = dpc_pkg::SL_MOD;
         `DPC_IDX_ZM: slot = dpc_pkg::SL_ZM;
         `DPC_IDX_SPD: slot = dpc_pkg::SL_SPD;
         `DPC_IDX_OVL: slot = dpc_pkg::SL_OVL;
         `DPC_IDX_ROT: slot = dpc_pkg::SL_ROT;
         `DPC_IDX_STL: slot = dpc_pkg::SL_STL;
         `DPC_IDX_STE: slot = dpc_pkg::SL_STE;
         `DPC_IDX_TOV: slot = dpc_pkg::SL_TOV;
         default: cfg_hit = 1'b0;
      endcase
   end

   always_comb begin
      in_range = 1'b0;
      unique case (slot)
         dpc_pkg::SL_OTL: in_range = pwdata_i[15:0] >= `DPC_OTL_MIN &&
                                     pwdata_i[15:0] <= `DPC_OTL_MAX;
         dpc_pkg::SL_PR1, dpc_pkg::SL_PR2:
            in_range = pwdata_i[15:0] <= `DPC_PRB_MAX;
         dpc_pkg::SL_TOR, dpc_pkg::SL_MOD:
            in_range = pwdata_i[15:0] <= `DPC_SEL_MAX;
         dpc_pkg::SL_ZM: in_range = pwdata_i[15:0] <= `DPC_ZM_MAX &&
                                    standstill_i;
         dpc_pkg::SL_SPD, dpc_pkg::SL_ROT:
            in_range = pwdata_i[15:0] <= `DPC_FLT_MAX;
         dpc_pkg::SL_STL: in_range = pwdata_i[15:0] >= `DPC_STL_MIN;
         dpc_pkg::SL_RWY, dpc_pkg::SL_OVL, dpc_pkg::SL_STE,
         dpc_pkg::SL_TOV: in_range = pwdata_i[15:0] <= `DPC_BIN_MAX;
      endcase
   end

   always_comb begin
      rdval = 32'h0000_0000;
      acc_ok = 1'b1;
      if (cfg_hit) begin
         rdval = {16'h0000, r.cfg[slot]};
         acc_ok = !pwrite_i || in_range;
      end else begin
         case (idx)
            `DPC_IDX_STAT: rdval = 32'(r.stat);
            `DPC_IDX_MASK: rdval = 32'(r.mask);
            `DPC_IDX_SPDMON: rdval = {16'h0000, r.lp[0][23:8]};
            `DPC_IDX_LIVE: rdval = 32'({r.tstat, r.ev});
            default: acc_ok = 1'b0;
         endcase
         if (pwrite_i && idx != `DPC_IDX_MASK) begin
            acc_ok = 1'b0;
         end
      end
   end

   always_comb begin
      logic [23:0] x;
      logic signed [24:0] dif;
      logic [15:0] tau;
      logic ste;
      logic [`DPC_NST-1:0] clr;
      x = {motor_speed_i, 8'h00};
      dif = '0;
      tau = '0;
      ste = r.cfg[dpc_pkg::SL_STE][0];
      clr = '0;
      n = r;
      n.meta = {torque_off_trip_i, zero_mark_signal_i,
                probe_two_i, probe_one_i};
      n.syn = r.meta;
      // a level must stay past its threshold before the output follows
      for (int c = 0; c < 3; c++) begin
         if (r.syn[c] == r.flt[c]) begin
            n.fcnt[c] = 10'h000;
         end else if (r.fcnt[c] >= thr[c]) begin
            n.flt[c] = r.syn[c];
            n.fcnt[c] = 10'h000;
         end else begin
            n.fcnt[c] = r.fcnt[c] + 10'h001;
         end
      end
      n.ms_cnt = tick ? 17'h00000 : r.ms_cnt + 17'h00001;
      for (int c = 0; c < 2; c++) begin
         tau = (c == 0) ? r.cfg[dpc_pkg::SL_SPD] : r.cfg[dpc_pkg::SL_ROT];
         dif = $signed({x[23], x}) - $signed({r.lp[c][23], r.lp[c]});
         if (tick) begin
            if (tau == 16'h0000) begin
               n.lp[c] = x;
            end else begin
               n.lp[c] = r.lp[c] + 24'(dif >>> tc_shift(tau));
            end
         end
      end
      if (!(stall_overheat_i && ste)) begin
         n.stall_cnt = 16'h0000;
      end else if (tick && r.stall_cnt < r.cfg[dpc_pkg::SL_STL]) begin
         n.stall_cnt = r.stall_cnt + 16'h0001;
      end
      n.ev[`DPC_ST_OTEMP] = module_temp_i >= r.cfg[dpc_pkg::SL_OTL];
      n.ev[`DPC_ST_TOFF] = r.syn[3] &&
                           r.cfg[dpc_pkg::SL_TOR] == `DPC_TOR_FAULT;
      n.tstat = r.syn[3] &&
                r.cfg[dpc_pkg::SL_TOR] != `DPC_TOR_FAULT;
      n.ev[`DPC_ST_OVLW] = overload_warn_i &&
                           !r.cfg[dpc_pkg::SL_OVL][0];
      n.ev[`DPC_ST_OVLF] = overload_trip_i &&
                           !r.cfg[dpc_pkg::SL_OVL][0];
      n.ev[`DPC_ST_STALL] = stall_overheat_i && ste &&
                            r.stall_cnt >= r.cfg[dpc_pkg::SL_STL];
      n.ev[`DPC_ST_TOVF] = turn_overflow_i &&
                           !r.cfg[dpc_pkg::SL_TOV][0];
      n.ev[`DPC_ST_RWY] = runaway_detect_i &&
                          r.cfg[dpc_pkg::SL_RWY][0];
      // the warning alone never drives the fault output
      n.fault = |(n.ev & ~(`DPC_NST'(1) << `DPC_ST_OVLW));
      n.pready = setup;
      n.pslverr = setup && !acc_ok;
      n.prdata = (setup && !pwrite_i) ? rdval : 32'h0000_0000;
      if (done && !r.pslverr) begin
         if (pwrite_i && cfg_hit) begin
            n.cfg[slot] = pwdata_i[15:0];
         end else if (pwrite_i) begin
            n.mask = pwdata_i[`DPC_NST-1:0];
         end else if (idx == `DPC_IDX_STAT) begin
            clr = r.prdata[`DPC_NST-1:0]; // only the bits handed out
         end
      end
      // a new event in the clearing cycle survives the read
      n.stat = (r.stat & ~clr) | (n.ev & ~r.ev);
      n.irq = |(n.stat & n.mask);
      if (warm_restart_i) begin
         n.zm_act = r.cfg[dpc_pkg::SL_ZM][4:0];
      end
      if (sys_rst_i) begin
         n = '0;
         n.cfg[dpc_pkg::SL_RWY] = `DPC_RST_RWY;
         n.cfg[dpc_pkg::SL_OTL] = `DPC_RST_OTL;
         n.cfg[dpc_pkg::SL_PR1] = `DPC_RST_PRB;
         n.cfg[dpc_pkg::SL_PR2] = `DPC_RST_PRB;
         n.cfg[dpc_pkg::SL_TOR] = `DPC_RST_TOR;
         n.cfg[dpc_pkg::SL_MOD] = `DPC_RST_MOD;
         n.cfg[dpc_pkg::SL_ZM] = `DPC_RST_ZM;
         n.cfg[dpc_pkg::SL_SPD] = `DPC_RST_SPD;
         n.cfg[dpc_pkg::SL_OVL] = `DPC_RST_OVL;
         n.cfg[dpc_pkg::SL_ROT] = `DPC_RST_ROT;
         n.cfg[dpc_pkg::SL_STL] = `DPC_RST_STL;
         n.cfg[dpc_pkg::SL_STE] = `DPC_RST_STE;
         n.cfg[dpc_pkg::SL_TOV] = `DPC_RST_TOV;
         n.zm_act = 5'(`DPC_RST_ZM);
      end
   end

   always_ff @(posedge clk_i) begin
      r <= n;
   end

   assign prdata_o = r.prdata;
   assign pready_o = r.pready;
   assign pslverr_o = r.pslverr;
   assign overtemp_o = r.ev[`DPC_ST_OTEMP];
   assign probe_one_o = r.flt[0];
   assign probe_two_o = r.flt[1];
   assign zero_mark_o = r.flt[2];
   assign torque_off_status_o = r.tstat;
   assign torque_off_fault_o = r.ev[`DPC_ST_TOFF];
   assign motor_overload_warning_o = r.ev[`DPC_ST_OVLW];
   assign motor_overload_fault_o = r.ev[`DPC_ST_OVLF];
   assign locked_rotor_fault_o = r.ev[`DPC_ST_STALL];
   assign turn_overflow_fault_o = r.ev[`DPC_ST_TOVF];
   assign runaway_fault_o = r.ev[`DPC_ST_RWY];
   assign fault_o = r.fault;
   assign rotation_speed_o = r.lp[1][23:8];
   assign irq_o = r.irq;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_apb_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_bad_write;
      s_apb_setup ##1 (psel_i && penable_i && pwrite_i && pslverr_o);
   endsequence

   chk_runaway_gate: assert property (
      runaway_fault_o == $past(runaway_detect_i && r.cfg[0][0]))
      else $error("runaway fault not gated by its enable");
   chk_otemp_compare: assert property (
      overtemp_o == $past(module_temp_i >= r.cfg[1]))
      else $error("overtemperature compare wrong");
   chk_probe_follow: assert property (
      $changed(probe_one_o) |-> probe_one_o == $past(r.syn[0]) &&
      $past(r.fcnt[0]) >= $past(thr[0]))
      else $error("probe output changed before filter time");
   chk_sto_status: assert property (
      torque_off_status_o |-> !torque_off_fault_o && $past(r.syn[3]))
      else $error("torque-off status with fault");
   chk_sto_fault: assert property (
      $past(r.syn[3] && r.cfg[4] == `DPC_TOR_FAULT) |->
      torque_off_fault_o && fault_o)
      else $error("torque-off fault not raised");
   chk_zm_apply: assert property (
      !$past(warm_restart_i) && !$past(sys_rst_i) |-> $stable(r.zm_act))
      else $error("zero-mark filter changed without restart");
   chk_ovl_hide: assert property (
      $past(r.cfg[8][0]) |->
      !motor_overload_warning_o && !motor_overload_fault_o)
      else $error("overload reported while hidden");
   chk_stall_time: assert property (
      $rose(locked_rotor_fault_o) |-> $past(r.stall_cnt) >= $past(r.cfg[10]))
      else $error("stall fault before its time");
   chk_stall_off: assert property (
      !$past(r.cfg[11][0]) |-> !locked_rotor_fault_o)
      else $error("stall fault while detection disabled");
   chk_tovf_hide: assert property (
      turn_overflow_fault_o |-> !$past(r.cfg[12][0]))
      else $error("overflow fault while hidden");
   chk_rwy_reset: assert property (
      $past(sys_rst_i) |-> r.cfg[0] == 16'h0001)
      else $error("runaway enable not on after reset");
   chk_range_keep: assert property (
      s_bad_write |=> $stable(r.cfg))
      else $error("refused write changed a setting");
   chk_apb_answer: assert property (
      s_apb_setup |=> pready_o ##1 !pready_o)
      else $error("apb answer not in access cycle");
   chk_spd_follow: assert property (
      $past(tick && r.cfg[7] == 16'h0000) |->
      r.lp[0][23:8] == $past(motor_speed_i))
      else $error("speed monitor not following at zero filter");
   chk_rot_follow: assert property (
      $past(tick && r.cfg[9] == 16'h0000) |->
      rotation_speed_o == $past(motor_speed_i))
      else $error("rotation speed not following at zero filter");
endmodule

// >>> verilog/dpc_defines.svh
// Purpose: constants of the drive protection configuration block
// Assumes: 125 MHz system clock, APB register access
// Notes: register byte address is four times the register index
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH
`define DPC_CLK_NS 8
`define DPC_MS_NS 1000000
`define DPC_PROBE_UNIT_NS 10
`define DPC_ZM_UNIT_NS 25
`define DPC_IDX_RWY 8'h0D
`define DPC_IDX_OTL 8'h13
`define DPC_IDX_PR1 8'h14
`define DPC_IDX_PR2 8'h15
`define DPC_IDX_TOR 8'h16
`define DPC_IDX_MOD 8'h17
`define DPC_IDX_ZM 8'h18
`define DPC_IDX_SPD 8'h1A
`define DPC_IDX_OVL 8'h1B
`define DPC_IDX_ROT 8'h1C
`define DPC_IDX_STL 8'h21
`define DPC_IDX_STE 8'h22
`define DPC_IDX_TOV 8'h25
`define DPC_IDX_STAT 8'h40
`define DPC_IDX_MASK 8'h41
`define DPC_IDX_SPDMON 8'h42
`define DPC_IDX_LIVE 8'h43
`define DPC_RST_RWY 16'h0001
`define DPC_RST_OTL 16'h0087
`define DPC_RST_PRB 16'h00C8
`define DPC_RST_TOR 16'h0000
`define DPC_RST_MOD 16'h0001
`define DPC_RST_ZM 16'h000F
`define DPC_RST_SPD 16'h0032
`define DPC_RST_OVL 16'h0000
`define DPC_RST_ROT 16'h0032
`define DPC_RST_STL 16'h00C8
`define DPC_RST_STE 16'h0001
`define DPC_RST_TOV 16'h0000
`define DPC_OTL_MIN 16'h0078
`define DPC_OTL_MAX 16'h00AF
`define DPC_PRB_MAX 16'h0276
`define DPC_SEL_MAX 16'h0003
`define DPC_ZM_MAX 16'h001F
`define DPC_FLT_MAX 16'h1388
`define DPC_BIN_MAX 16'h0001
`define DPC_STL_MIN 16'h000A
`define DPC_TOR_FAULT 16'h0001
`define DPC_ST_OTEMP 0
`define DPC_ST_TOFF 1
`define DPC_ST_OVLW 2
`define DPC_ST_OVLF 3
`define DPC_ST_STALL 4
`define DPC_ST_TOVF 5
`define DPC_ST_RWY 6
`define DPC_NST 7
`endif

// >>> verilog/dpc_pkg.sv
// Purpose: types of the drive protection configuration block
// Assumes: constants come from dpc_defines.svh
// Notes: all block state is one packed struct
`include "dpc_defines.svh"
package dpc_pkg;
   typedef logic [15:0] dpc_word_t;
   typedef enum logic [3:0] {
      SL_RWY, SL_OTL, SL_PR1, SL_PR2, SL_TOR, SL_MOD, SL_ZM,
      SL_SPD, SL_OVL, SL_ROT, SL_STL, SL_STE, SL_TOV
   } dpc_slot_t;
   typedef dpc_word_t [12:0] dpc_cfg_t;
   typedef struct packed {
      dpc_cfg_t cfg;
      logic [4:0] zm_act;
      logic [3:0] meta;
      logic [3:0] syn;
      logic [2:0] flt;
      logic [2:0][9:0] fcnt;
      logic [16:0] ms_cnt;
      logic [1:0][23:0] lp;
      logic [15:0] stall_cnt;
      logic [`DPC_NST-1:0] ev;
      logic tstat;
      logic fault;
      logic [`DPC_NST-1:0] stat;
      logic [`DPC_NST-1:0] mask;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } dpc_state_t;
endpackage

// >>> bench/dpc_host_model.sv
// Purpose: host controller model, APB master writing drive settings
// Assumes: one clock, request changed only right after a rising edge
// Notes: released address and data lines show inverted last value
`timescale 1ns/1ps
module dpc_host_model (
   input wire logic clk_i,
   input wire logic pready_i,
   input wire logic pslverr_i,
   input wire logic [31:0] prdata_i,
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [9:0] paddr_o,
   output logic [31:0] pwdata_o
);
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 10'h000;
      pwdata_o = 32'h00000000;
   end
   // values stay in range unless a scenario asks for a refusal
   task automatic xfer(input logic w, input logic [7:0] i,
                       input logic [15:0] d, output logic [15:0] r,
                       output logic e);
      @(posedge clk_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= {i, 2'b00};
      pwdata_o <= {16'h0000, d};
      @(posedge clk_i);
      penable_o <= 1'b1;
      @(posedge clk_i);
      while (pready_i !== 1'b1) @(posedge clk_i);
      r = prdata_i[15:0];
      e = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      paddr_o <= ~paddr_o;
      pwdata_o <= ~pwdata_o;
   endtask
endmodule

// >>> bench/tb.sv
// Purpose: self-checking bench of the protection settings block
// Assumes: ms tick shortened to 10 cycles
// Notes: waits after pin changes cover sync and output registers
`timescale 1ns/1ps
`include "dpc_defines.svh"
module tb;
   logic clk_i, sys_rst_i, psel, pen, pwr, rdy, err;
   logic [9:0] addr;
   logic [31:0] wd, rdat;
   logic [15:0] temp, spd, rot;
   logic p1, p2, tr, sst, ow, ot, so, tv, rw, zm, wrs;
   logic o_ot, o_p1, o_p2, o_ts, o_tf, o_ow, o_of, o_lr, o_tv, o_rw;
   logic o_zm;
   logic o_f, o_irq;
   int mismatches, check_count, cycles;
   dpc_top #(.MS_CYCLES(10)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr),
      .pwdata_i(wd), .prdata_o(rdat), .pready_o(rdy), .pslverr_o(err),
      .module_temp_i(temp), .motor_speed_i(spd), .probe_one_i(p1),
      .probe_two_i(p2), .zero_mark_signal_i(zm),
      .torque_off_trip_i(tr), .standstill_i(sst), .warm_restart_i(wrs),
      .overload_warn_i(ow), .overload_trip_i(ot),
      .stall_overheat_i(so), .turn_overflow_i(tv),
      .runaway_detect_i(rw), .overtemp_o(o_ot), .probe_one_o(o_p1),
      .probe_two_o(o_p2), .zero_mark_o(o_zm), .torque_off_status_o(o_ts),
      .torque_off_fault_o(o_tf), .motor_overload_warning_o(o_ow),
      .motor_overload_fault_o(o_of), .locked_rotor_fault_o(o_lr),
      .turn_overflow_fault_o(o_tv), .runaway_fault_o(o_rw),
      .fault_o(o_f), .rotation_speed_o(rot), .irq_o(o_irq));
   dpc_host_model i_host (.clk_i(clk_i), .pready_i(rdy),
      .pslverr_i(err), .prdata_i(rdat), .psel_o(psel), .penable_o(pen),
      .pwrite_o(pwr), .paddr_o(addr), .pwdata_o(wd));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task automatic ck(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic [7:0] i, input logic [15:0] d,
                     input logic e);
      logic [15:0] r;
      logic x;
      i_host.xfer(1'b1, i, d, r, x);
      ck(x === e, "write response");
   endtask
   task automatic rd(input logic [7:0] i, input logic [15:0] d);
      logic [15:0] r;
      logic x;
      i_host.xfer(1'b0, i, d, r, x);
      ck(x === 1'b0 && r === d, "read value");
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic t_reset;
      logic [7:0] ix[13] = '{8'h0D, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
         8'h18, 8'h1A, 8'h1B, 8'h1C, 8'h21, 8'h22, 8'h25};
      logic [15:0] dv[13] = '{16'h0001, 16'h0087, 16'h00C8, 16'h00C8,
         16'h0000, 16'h0001, 16'h000F, 16'h0032, 16'h0000, 16'h0032,
         16'h00C8, 16'h0001, 16'h0000};
      for (int k = 0; k < 13; k++) rd(ix[k], dv[k]);
      wr(8'h3F, 16'h0000, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_irq;
      ow <= 1'b1;
      cyc(4);
      ck(o_ow === 1'b1 && o_irq === 1'b0, "masked event");
      wr(`DPC_IDX_MASK, 16'h0004, 1'b0);
      cyc(2);
      ck(o_irq === 1'b1, "irq raised");
      rd(`DPC_IDX_STAT, 16'h0004);
      cyc(2);
      ck(o_irq === 1'b0, "irq cleared");
      rd(`DPC_IDX_STAT, 16'h0000);
      wr(`DPC_IDX_STAT, 16'h0000, 1'b1);
      wr(`DPC_IDX_MASK, 16'h0000, 1'b0);
      $display("test irq done");
   endtask
   task automatic t_temp;
      temp <= 16'h0082;
      cyc(3);
      ck(o_ot === 1'b0, "below limit");
      wr(`DPC_IDX_OTL, 16'h0077, 1'b1);
      wr(`DPC_IDX_OTL, 16'h00B0, 1'b1);
      wr(`DPC_IDX_OTL, 16'h0078, 1'b0);
      cyc(2);
      ck(o_ot === 1'b1 && o_f === 1'b1, "over limit");
      wr(`DPC_IDX_OTL, 16'h00AF, 1'b0);
      rd(`DPC_IDX_OTL, 16'h00AF);
      temp <= 16'h0000;
      $display("test temperature done");
   endtask
   task automatic t_sto;
      tr <= 1'b1;
      cyc(6);
      ck(o_ts === 1'b1 && o_tf === 1'b0 && o_f === 1'b0, "status");
      wr(`DPC_IDX_TOR, 16'h0001, 1'b0);
      cyc(2);
      ck(o_ts === 1'b0 && o_tf === 1'b1 && o_f === 1'b1, "fault");
      wr(`DPC_IDX_TOR, 16'h0004, 1'b1);
      wr(`DPC_IDX_TOR, 16'h0000, 1'b0);
      tr <= 1'b0;
      $display("test torque off done");
   endtask
   task automatic t_masks;
      ot <= 1'b1;
      tv <= 1'b1;
      rw <= 1'b1;
      cyc(3);
      ck(o_of === 1'b1 && o_tv === 1'b1, "reported");
      ck(o_rw === 1'b1, "runaway on");
      wr(`DPC_IDX_OVL, 16'h0001, 1'b0);
      wr(`DPC_IDX_TOV, 16'h0001, 1'b0);
      wr(`DPC_IDX_RWY, 16'h0000, 1'b0);
      wr(`DPC_IDX_RWY, 16'h0002, 1'b1);
      cyc(2);
      ck(o_of === 1'b0 && o_ow === 1'b0, "overload hidden");
      ck(o_tv === 1'b0 && o_rw === 1'b0, "hidden");
      rd(`DPC_IDX_RWY, 16'h0000);
      {ow, ot, tv, rw} <= 4'h0;
      $display("test masks done");
   endtask
   task automatic t_stall;
      wr(`DPC_IDX_STL, 16'h0009, 1'b1);
      wr(`DPC_IDX_STL, 16'h000A, 1'b0);
      so <= 1'b1;
      cyc(80);
      ck(o_lr === 1'b0, "stall early");
      cyc(40);
      ck(o_lr === 1'b1, "stall fault");
      wr(`DPC_IDX_STE, 16'h0000, 1'b0);
      cyc(150);
      ck(o_lr === 1'b0, "stall off");
      so <= 1'b0;
      wr(`DPC_IDX_STE, 16'h0001, 1'b0);
      $display("test stall done");
   endtask
   task automatic t_filters;
      wr(`DPC_IDX_PR1, 16'h0000, 1'b0);
      wr(`DPC_IDX_PR2, 16'h0276, 1'b0);
      wr(`DPC_IDX_PR1, 16'h0277, 1'b1);
      {p1, p2} <= 2'b11;
      cyc(12);
      ck(o_p1 === 1'b1 && o_p2 === 1'b0, "spike filter");
      {p1, p2} <= 2'b00;
      wr(`DPC_IDX_SPD, 16'h0000, 1'b0);
      wr(`DPC_IDX_ROT, 16'h0000, 1'b0);
      wr(`DPC_IDX_ROT, 16'h1389, 1'b1);
      spd <= 16'h1234;
      cyc(40);
      rd(`DPC_IDX_SPDMON, 16'h1234);
      ck(rot === 16'h1234 && o_p1 === 1'b0, "rotation speed");
      wr(`DPC_IDX_ZM, 16'h0003, 1'b1);
      sst <= 1'b1;
      wr(`DPC_IDX_ZM, 16'h0020, 1'b1);
      wr(`DPC_IDX_ZM, 16'h001F, 1'b0);
      rd(`DPC_IDX_ZM, 16'h001F);
      $display("test filters done");
   endtask
   task automatic t_zero;
      zm <= 1'b1;
      cyc(40);
      ck(o_zm === 1'b0, "zero-mark spike passed");
      cyc(20);
      ck(o_zm === 1'b1, "zero-mark old filter");
      zm <= 1'b0;
      cyc(60);
      wrs <= 1'b1;
      cyc(1);
      wrs <= 1'b0;
      zm <= 1'b1;
      cyc(80);
      ck(o_zm === 1'b0, "zero-mark new filter early");
      cyc(40);
      ck(o_zm === 1'b1, "zero-mark new filter");
      zm <= 1'b0;
      $display("test zero mark done");
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up;
      end
   end
   initial begin
      sys_rst_i = 1'b1;
      {p1, p2, tr, sst, ow, ot, so, tv, rw} = 9'h000;
      {zm, wrs} = 2'b00;
      temp = 16'h0000;
      spd = 16'h0000;
      cyc(3);
      sys_rst_i <= 1'b0;
      t_reset;
      t_irq;
      t_temp;
      t_sto;
      t_masks;
      t_stall;
      t_filters;
      t_zero;
      wrap_up;
   end
endmodule
